// ### mrpb_ramp_bank.sv
// Motion ramp parameter bank with speed clamping and following-error check.
//
// Functional notes
// - Packed ramp: acceleration high word, deceleration low.
// - Packed halves are in 10 rpm/s units.
// - Packed write updates both ramps, each range-checked.
// - Ramp views saturate at 16-bit maximum.
// - Symmetric write sets both ramps, each checked.
// - Symmetric read returns larger of both ramps.
// - Acceleration 1 to 3000000, factory 600.
// - Deceleration 750 to 3000000, factory 750.
// - Profile modes clamp reference speed to ceiling.
// - Stop or class-1 error uses halt ramp.
// - Setpoint -30000..30000, limited to controller maximum.
// - Source select: none, analog input, setpoint.
// - Following error raises configured class 1..3.
// - Deviation compared to limit 0.0001..200 revolutions.
// - Persistent settings announced; symmetric, source, setpoint and halt ramp not.
`timescale 1ns/100ps
module mrpb_ramp_bank
  import mrpb_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire mrpb_req_t          paramReq,
  output mrpb_rsp_t               paramRsp,
  input  wire mrpb_mode_t         opMode,
  input  wire logic signed [15:0] requestedSpeed,
  input  wire logic        [15:0] controllerMaxSpeed,
  input  wire logic signed [15:0] analogInputOne,
  input  wire logic               softwareStop,
  input  wire logic               errorClassOne,
  input  wire logic signed [31:0] positionDeviation,
  output logic signed      [15:0] profileSpeed,
  output logic signed      [15:0] speedCommand,
  output logic             [31:0] activeAcceleration,
  output logic             [31:0] activeDeceleration,
  output logic                    followingErrorEvent,
  output logic             [1:0]  followingErrorClass,
  output logic                    persistentUpdate,
  output logic             [15:0] persistentAddr
);

  logic        [31:0] accel_reg;
  logic        [31:0] decel_reg;
  logic        [31:0] haltDecel_reg;
  logic        [15:0] speedCeil_reg;
  logic        [31:0] feLimit_reg;
  logic        [15:0] feClass_reg;
  mrpb_src_t          speedSrc_reg;
  logic signed [15:0] setpoint_reg;
  mrpb_rsp_t          rsp_reg;
  logic               feOver_reg;
  logic               persist_reg;
  logic        [15:0] persistAddr_reg;
  logic signed [15:0] profSpeed_reg;
  logic signed [15:0] speedCmd_reg;
  logic        [31:0] actAcc_reg;
  logic        [31:0] actDec_reg;
  logic               feEvent_reg;
  logic        [1:0]  feClassOut_reg;

  logic        [31:0] packedRead;
  logic        [15:0] symRead;
  logic        [31:0] packAcc;
  logic        [31:0] packDec;
  logic        [31:0] symVal;
  logic               packOk;
  logic               symOk;

  logic               wrAccept;
  logic               mapped;
  logic        [31:0] rdValue;
  logic        [31:0] feAbs;
  logic signed [15:0] srcSpeed;

  mrpb_ramp_calc u_calc (
    .accVal     (accel_reg),
    .decVal     (decel_reg),
    .wrData     (paramReq.data),
    .packedRead (packedRead),
    .symRead    (symRead),
    .packAcc    (packAcc),
    .packDec    (packDec),
    .symVal     (symVal),
    .packOk     (packOk),
    .symOk      (symOk)
  );

  // Limits a signed speed symmetrically to a magnitude ceiling.
  function automatic logic signed [15:0] clampSpeed(
    input logic signed [15:0] v,
    input logic        [15:0] lim
  );
    logic signed [16:0] vw;
    logic signed [16:0] lw;
    vw = {v[15], v};
    lw = {1'b0, lim};
    if (vw > lw) begin
      return lw[15:0];
    end else if (vw < -lw) begin
      return 16'(-lw);
    end else begin
      return v;
    end
  endfunction

  function automatic logic isPersistent(input logic [15:0] a);
    return (a == ADDR_PROFILE_ACC) || (a == ADDR_PROFILE_DEC) ||
           (a == ADDR_PACKED_RAMP) || (a == ADDR_SPEED_CEIL) ||
           (a == ADDR_FE_LIMIT) || (a == ADDR_FE_RESPONSE);
  endfunction

  // Address decode, write range check and read multiplexer.
  always_comb begin
    mapped   = 1'b1;
    wrAccept = 1'b0;
    rdValue  = 32'h0000_0000;
    unique case (paramReq.addr)
      ADDR_PROFILE_ACC: begin
        rdValue  = accel_reg;
        wrAccept = (paramReq.data >= ACC_MIN) &&
                   (paramReq.data <= RAMP_MAX);
      end
      ADDR_PROFILE_DEC: begin
        rdValue  = decel_reg;
        wrAccept = (paramReq.data >= DEC_MIN) &&
                   (paramReq.data <= RAMP_MAX);
      end
      ADDR_PACKED_RAMP: begin
        rdValue  = packedRead;
        wrAccept = packOk;
      end
      ADDR_SYM_RAMP: begin
        rdValue  = {16'h0000, symRead};
        wrAccept = symOk;
      end
      ADDR_HALT_DECEL: begin
        rdValue  = haltDecel_reg;
        wrAccept = (paramReq.data >= HALT_MIN) &&
                   (paramReq.data <= RAMP_MAX);
      end
      ADDR_SPEED_CEIL: begin
        rdValue  = {16'h0000, speedCeil_reg};
        wrAccept = (paramReq.data[31:16] == 16'h0000);
      end
      ADDR_FE_LIMIT: begin
        rdValue  = feLimit_reg;
        wrAccept = (paramReq.data >= FE_LIMIT_MIN) &&
                   (paramReq.data <= FE_LIMIT_MAX);
      end
      ADDR_FE_RESPONSE: begin
        rdValue  = {16'h0000, feClass_reg};
        wrAccept = (paramReq.data[31:16] == 16'h0000) &&
                   (paramReq.data[15:0] >= FE_CLASS_MIN) &&
                   (paramReq.data[15:0] <= FE_CLASS_MAX);
      end
      ADDR_SPEED_SOURCE: begin
        rdValue  = {30'h0000_0000, speedSrc_reg};
        wrAccept = (paramReq.data <= 32'(MRPB_SRC_PARAM));
      end
      ADDR_SPEED_SETPT: begin
        rdValue  = {16'h0000, setpoint_reg};
        wrAccept = ($signed(paramReq.data) <= $signed({16'h0000, SETPT_MAX}))
                && ($signed(paramReq.data) >=
                    -$signed({16'h0000, SETPT_MAX}));
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Ramp storage; both ramps of a packed or symmetric write move at once.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      accel_reg     <= ACC_RESET;
      decel_reg     <= DEC_RESET;
      haltDecel_reg <= HALT_RESET;
    end else if (paramReq.wr && wrAccept) begin
      unique case (paramReq.addr)
        ADDR_PROFILE_ACC: accel_reg <= paramReq.data;
        ADDR_PROFILE_DEC: decel_reg <= paramReq.data;
        ADDR_PACKED_RAMP: begin
          accel_reg <= packAcc;
          decel_reg <= packDec;
        end
        ADDR_SYM_RAMP: begin
          accel_reg   <= symVal;
          decel_reg   <= symVal;
        end
        ADDR_HALT_DECEL: haltDecel_reg <= paramReq.data;
        default: begin
        end
      endcase
    end
  end

  // Speed, following-error and source settings.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      speedCeil_reg <= CEIL_RESET;
      feLimit_reg   <= FE_LIMIT_RESET;
      feClass_reg   <= FE_CLASS_RESET;
      speedSrc_reg  <= MRPB_SRC_NONE;
      setpoint_reg  <= SETPT_RESET;
    end else if (paramReq.wr && wrAccept) begin
      unique case (paramReq.addr)
        ADDR_SPEED_CEIL:   speedCeil_reg <= paramReq.data[15:0];
        ADDR_FE_LIMIT:     feLimit_reg   <= paramReq.data;
        ADDR_FE_RESPONSE:  feClass_reg   <= paramReq.data[15:0];
        ADDR_SPEED_SOURCE: speedSrc_reg  <= mrpb_src_t'(paramReq.data[1:0]);
        ADDR_SPEED_SETPT:  setpoint_reg  <= paramReq.data[15:0];
        default: begin
        end
      endcase
    end
  end

  // Access answer one cycle after the request; bad address or value errs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.ack  <= paramReq.wr || paramReq.rd;
      rsp_reg.err  <= (paramReq.wr || paramReq.rd) &&
                      (!mapped || (paramReq.wr && !wrAccept));
      rsp_reg.data <= (paramReq.rd && mapped) ? rdValue : 32'h0000_0000;
    end
  end

  // Notifies the retention store of an accepted write to a kept setting.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      persist_reg     <= 1'b0;
      persistAddr_reg <= 16'h0000;
    end else begin
      persist_reg <= paramReq.wr && wrAccept &&
                     isPersistent(paramReq.addr);
      if (paramReq.wr && wrAccept) begin
        persistAddr_reg <= paramReq.addr;
      end
    end
  end

  // Reference speed ceiling in profile-generating modes.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      profSpeed_reg <= 16'sh0000;
    end else begin
      unique case (opMode)
        MRPB_MODE_PROF_POS, MRPB_MODE_PROF_VEL,
        MRPB_MODE_HOMING, MRPB_MODE_JOG:
          profSpeed_reg <= clampSpeed(requestedSpeed, speedCeil_reg);
        default:
          profSpeed_reg <= requestedSpeed;
      endcase
    end
  end

  always_comb begin
    unique case (speedSrc_reg)
      MRPB_SRC_ANALOG: srcSpeed = analogInputOne;
      MRPB_SRC_PARAM:  srcSpeed = setpoint_reg;
      default:         srcSpeed = 16'sh0000;
    endcase
  end

  // Speed-control command, held at zero outside speed-control mode.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      speedCmd_reg <= 16'sh0000;
    end else if (opMode == MRPB_MODE_SPEED) begin
      speedCmd_reg <= clampSpeed(srcSpeed, controllerMaxSpeed);
    end else begin
      speedCmd_reg <= 16'sh0000;
    end
  end

  // Ramp handed to the profile generator; a stop swaps in the halt ramp.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      actAcc_reg <= ACC_RESET;
      actDec_reg <= DEC_RESET;
    end else begin
      actAcc_reg <= accel_reg;
      actDec_reg <= (softwareStop || errorClassOne) ?
                    haltDecel_reg : decel_reg;
    end
  end

  assign feAbs = positionDeviation[31] ? 32'(-positionDeviation)
                                       : positionDeviation;

  // Following-error event fires once as the deviation crosses the limit.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      feOver_reg     <= 1'b0;
      feEvent_reg    <= 1'b0;
      feClassOut_reg <= FE_CLASS_RESET[1:0];
    end else begin
      feOver_reg  <= feAbs > feLimit_reg;
      feEvent_reg <= (feAbs > feLimit_reg) && !feOver_reg;
      if ((feAbs > feLimit_reg) && !feOver_reg) begin
        feClassOut_reg <= feClass_reg[1:0];
      end
    end
  end

  assign paramRsp            = rsp_reg;
  assign profileSpeed        = profSpeed_reg;
  assign speedCommand        = speedCmd_reg;
  assign activeAcceleration  = actAcc_reg;
  assign activeDeceleration  = actDec_reg;
  assign followingErrorEvent = feEvent_reg;
  assign followingErrorClass = feClassOut_reg;
  assign persistentUpdate    = persist_reg;
  assign persistentAddr      = persistAddr_reg;

endmodule // mrpb_ramp_bank

// ### mrpb_pkg.sv
// Package with the motion ramp parameter bank's addresses, limits and types.
package mrpb_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  localparam logic [15:0] ADDR_FE_RESPONSE  = 16'h0516;
  localparam logic [15:0] ADDR_SYM_RAMP     = 16'h0602;
  localparam logic [15:0] ADDR_SPEED_CEIL   = 16'h0612;
  localparam logic [15:0] ADDR_PROFILE_ACC  = 16'h0614;
  localparam logic [15:0] ADDR_PROFILE_DEC  = 16'h0616;
  localparam logic [15:0] ADDR_PACKED_RAMP  = 16'h0618;
  localparam logic [15:0] ADDR_HALT_DECEL   = 16'h061A;
  localparam logic [15:0] ADDR_FE_LIMIT     = 16'h121C;
  localparam logic [15:0] ADDR_SPEED_SOURCE = 16'h2102;
  localparam logic [15:0] ADDR_SPEED_SETPT  = 16'h2108;

  localparam logic [31:0] RAMP_UNIT      = 32'h0000_000A;
  localparam logic [31:0] ACC_MIN        = 32'h0000_0001;
  localparam logic [31:0] ACC_RESET      = 32'h0000_0258;
  localparam logic [31:0] DEC_MIN        = 32'h0000_02EE;
  localparam logic [31:0] DEC_RESET      = 32'h0000_02EE;
  localparam logic [31:0] RAMP_MAX       = 32'h002D_C6C0;
  localparam logic [31:0] HALT_MIN       = 32'h0000_00C8;
  localparam logic [31:0] HALT_RESET     = 32'h0000_1770;
  localparam logic [15:0] U16_MAX        = 16'hFFFF;
  localparam logic [15:0] CEIL_RESET     = 16'h0BB8;
  localparam logic [31:0] FE_LIMIT_MIN   = 32'h0000_0001;
  localparam logic [31:0] FE_LIMIT_RESET = 32'h0000_2710;
  localparam logic [31:0] FE_LIMIT_MAX   = 32'h001E_8480;
  localparam logic [15:0] FE_CLASS_MIN   = 16'h0001;
  localparam logic [15:0] FE_CLASS_RESET = 16'h0003;
  localparam logic [15:0] FE_CLASS_MAX   = 16'h0003;
  localparam logic [15:0] SETPT_MAX      = 16'h7530;
  localparam logic [15:0] SETPT_RESET    = 16'h0000;
  localparam logic [15:0] SYM_RESET      = 16'h0000;

  typedef enum logic [1:0] {
    MRPB_SRC_NONE   = 2'h0,
    MRPB_SRC_ANALOG = 2'h1,
    MRPB_SRC_PARAM  = 2'h2
  } mrpb_src_t;

  typedef enum logic [2:0] {
    MRPB_MODE_IDLE     = 3'h0,
    MRPB_MODE_PROF_POS = 3'h1,
    MRPB_MODE_PROF_VEL = 3'h2,
    MRPB_MODE_HOMING   = 3'h3,
    MRPB_MODE_JOG      = 3'h4,
    MRPB_MODE_SPEED    = 3'h5
  } mrpb_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mrpb_req_t;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] data;
  } mrpb_rsp_t;

endpackage

// ### mrpb_ramp_calc.sv
// Conversion between the 10 rpm/s ramp views and the full-rate ramp values.
`timescale 1ns/100ps
module mrpb_ramp_calc
  import mrpb_pkg::*;
(
  input  wire logic [31:0] accVal,
  input  wire logic [31:0] decVal,
  input  wire logic [31:0] wrData,
  output logic      [31:0] packedRead,
  output logic      [15:0] symRead,
  output logic      [31:0] packAcc,
  output logic      [31:0] packDec,
  output logic      [31:0] symVal,
  output logic             packOk,
  output logic             symOk
);

  logic [15:0] accHalf;
  logic [15:0] decHalf;

  function automatic logic [15:0] sat16(input logic [31:0] v);
    logic [31:0] q;
    q = v / RAMP_UNIT;
    return (q > {16'h0000, U16_MAX}) ? U16_MAX : q[15:0];
  endfunction

  function automatic logic accOk(input logic [31:0] v);
    return (v >= ACC_MIN) && (v <= RAMP_MAX);
  endfunction

  function automatic logic decOk(input logic [31:0] v);
    return (v >= DEC_MIN) && (v <= RAMP_MAX);
  endfunction

  always_comb begin
    accHalf    = sat16(accVal);
    decHalf    = sat16(decVal);
    packedRead = {accHalf, decHalf};
    symRead    = (accVal >= decVal) ? accHalf : decHalf;
    packAcc    = {16'h0000, wrData[31:16]} * RAMP_UNIT;
    packDec    = {16'h0000, wrData[15:0]} * RAMP_UNIT;
    symVal     = {16'h0000, wrData[15:0]} * RAMP_UNIT;
    packOk     = accOk(packAcc) && decOk(packDec);
    symOk      = accOk(symVal) && decOk(symVal);
  end

endmodule // mrpb_ramp_calc

// ### mrpb_ramp_bank_asserts.sv
// Concurrent checks on the ports of the ramp parameter bank.
`timescale 1ns/100ps
module mrpb_ramp_bank_asserts
  import mrpb_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire mrpb_req_t          paramReq,
  input wire mrpb_rsp_t          paramRsp,
  input wire mrpb_mode_t         opMode,
  input wire logic signed [15:0] requestedSpeed,
  input wire logic        [15:0] controllerMaxSpeed,
  input wire logic               softwareStop,
  input wire logic               errorClassOne,
  input wire logic signed [31:0] positionDeviation,
  input wire logic signed [15:0] profileSpeed,
  input wire logic signed [15:0] speedCommand,
  input wire logic        [31:0] activeDeceleration,
  input wire logic               followingErrorEvent,
  input wire logic        [1:0]  followingErrorClass,
  input wire logic               persistentUpdate,
  input wire logic        [15:0] persistentAddr
);
  logic [1:0] upCnt;
  logic       up;
  // Runtime checks wait until outputs no longer show their reset values.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      upCnt <= 2'h0;
    end else if (upCnt != 2'h3) begin
      upCnt <= upCnt + 2'h1;
    end
  end
  assign up = (upCnt == 2'h3);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence reqSeq; paramReq.wr || paramReq.rd; endsequence
  sequence answerSeq; paramRsp.ack; endsequence
  sequence rejectSeq; paramRsp.ack && paramRsp.err; endsequence

  access_ack_a: assert property (reqSeq |=> answerSeq)
    else $error("Request not answered one cycle later.");
  lone_ack_a: assert property (
    answerSeq |-> $past(paramReq.wr) || $past(paramReq.rd))
    else $error("Answer without a request.");
  acc_range_a: assert property (paramReq.wr &&
    paramReq.addr == ADDR_PROFILE_ACC && paramReq.data == 32'h0 |=> rejectSeq)
    else $error("Zero acceleration accepted.");
  dec_range_a: assert property (paramReq.wr &&
    paramReq.addr == ADDR_PROFILE_DEC && paramReq.data < DEC_MIN |=> rejectSeq)
    else $error("Low deceleration accepted.");
  reject_quiet_a: assert property (rejectSeq |-> !persistentUpdate)
    else $error("Rejected write marked as stored.");
  kept_write_a: assert property (persistentUpdate |->
    answerSeq ##0 !paramRsp.err && $past(paramReq.wr) &&
    persistentAddr == $past(paramReq.addr))
    else $error("Retention mark without accepted write.");
  sym_unkept_a: assert property (paramReq.wr &&
    paramReq.addr == ADDR_SYM_RAMP |=> !persistentUpdate)
    else $error("Symmetric ramp marked for retention.");
  speed_pass_a: assert property (up && opMode == MRPB_MODE_IDLE
    |=> profileSpeed == $past(requestedSpeed))
    else $error("Reference speed altered outside profile modes.");
  speed_idle_a: assert property (up && opMode != MRPB_MODE_SPEED
    |=> speedCommand == 16'h0000)
    else $error("Speed command outside speed control.");
  speed_limit_a: assert property (up && opMode == MRPB_MODE_SPEED
    |=> int'(speedCommand) <= int'($past(controllerMaxSpeed)) &&
    -int'(speedCommand) <= int'($past(controllerMaxSpeed)))
    else $error("Speed command beyond controller maximum.");
  halt_ramp_a: assert property (up && (softwareStop || errorClassOne)
    |=> activeDeceleration >= HALT_MIN && activeDeceleration <= RAMP_MAX)
    else $error("Halt ramp out of range during stop.");
  fe_pulse_a: assert property (followingErrorEvent |=>
    !followingErrorEvent)
    else $error("Following error event longer than one cycle.");
  fe_cause_a: assert property (followingErrorEvent |->
    $past(positionDeviation) != 32'sh0)
    else $error("Following error event with zero deviation.");
  fe_class_a: assert property (followingErrorClass != 2'h0)
    else $error("Following error class zero.");
endmodule // mrpb_ramp_bank_asserts

bind mrpb_ramp_bank mrpb_ramp_bank_asserts u_chk (
  .core_clk(core_clk), .rstn(rstn), .paramReq(paramReq),
  .paramRsp(paramRsp), .opMode(opMode), .requestedSpeed(requestedSpeed),
  .controllerMaxSpeed(controllerMaxSpeed), .softwareStop(softwareStop),
  .errorClassOne(errorClassOne), .positionDeviation(positionDeviation),
  .profileSpeed(profileSpeed), .speedCommand(speedCommand),
  .activeDeceleration(activeDeceleration),
  .followingErrorEvent(followingErrorEvent),
  .followingErrorClass(followingErrorClass),
  .persistentUpdate(persistentUpdate), .persistentAddr(persistentAddr)
);

// ### mrpb_master_model.sv
// Fieldbus master model issuing single parameter accesses.
`timescale 1ns/100ps
module mrpb_master_model
  import mrpb_pkg::*;
(
  input  wire logic      core_clk,
  output mrpb_req_t      paramReq,
  input  wire mrpb_rsp_t paramRsp
);
  initial paramReq = '0;
  // One request pulse per call; released lines carry inverted values.
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e, output logic ok);
    ok = 1'b0;
    q = '0;
    e = 1'b0;
    @(negedge core_clk);
    paramReq = '{wr: w, rd: !w, addr: a, data: d};
    @(negedge core_clk);
    paramReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    for (int n = 0; n < 3 && !ok; n++) begin
      if (paramRsp.ack === 1'b1) begin
        ok = 1'b1;
        q = paramRsp.data;
        e = paramRsp.err;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask
endmodule // mrpb_master_model

// ### mrpb_ramp_bank_tb_top.sv
// Self-checking bench for the motion ramp parameter bank.
`timescale 1ns/100ps
module mrpb_ramp_bank_tb_top
  import mrpb_pkg::*;
;
  logic               core_clk = 1'b0;
  logic               rstn = 1'b0;
  mrpb_req_t          paramReq;
  mrpb_rsp_t          paramRsp;
  mrpb_mode_t         opMode = MRPB_MODE_IDLE;
  logic signed [15:0] requestedSpeed = '0;
  logic        [15:0] controllerMaxSpeed = '0;
  logic signed [15:0] analogInputOne = '0;
  logic               softwareStop = 1'b0;
  logic               errorClassOne = 1'b0;
  logic signed [31:0] positionDeviation = '0;
  logic signed [15:0] profileSpeed;
  logic signed [15:0] speedCommand;
  logic        [31:0] activeAcceleration;
  logic        [31:0] activeDeceleration;
  logic               followingErrorEvent;
  logic        [1:0]  followingErrorClass;
  logic               persistentUpdate;
  logic        [15:0] persistentAddr;
  logic               seen;
  int                 failures = 0;
  int                 checkCount = 0;
  logic [15:0] rstAddr [10] = '{ADDR_PROFILE_ACC, ADDR_PROFILE_DEC,
    ADDR_HALT_DECEL, ADDR_SPEED_CEIL, ADDR_FE_LIMIT, ADDR_FE_RESPONSE,
    ADDR_SPEED_SOURCE, ADDR_SPEED_SETPT, ADDR_SYM_RAMP, ADDR_PACKED_RAMP};
  logic [31:0] rstVal [10] = '{32'h0000_0258, 32'h0000_02EE, 32'h0000_1770,
    32'h0000_0BB8, 32'h0000_2710, 32'h0000_0003, 32'h0000_0000,
    32'h0000_0000, 32'h0000_004B, 32'h003C_004B};
  logic [15:0] srcExp [3] = '{16'h0000, 16'hFED4, 16'h03E8};

  always #5 core_clk = ~core_clk;

  mrpb_master_model bfm (.core_clk(core_clk), .paramReq(paramReq),
                         .paramRsp(paramRsp));
  mrpb_ramp_bank uut (.core_clk(core_clk), .rstn(rstn),
    .paramReq(paramReq), .paramRsp(paramRsp), .opMode(opMode),
    .requestedSpeed(requestedSpeed), .controllerMaxSpeed(controllerMaxSpeed),
    .analogInputOne(analogInputOne), .softwareStop(softwareStop),
    .errorClassOne(errorClassOne), .positionDeviation(positionDeviation),
    .profileSpeed(profileSpeed), .speedCommand(speedCommand),
    .activeAcceleration(activeAcceleration),
    .activeDeceleration(activeDeceleration),
    .followingErrorEvent(followingErrorEvent),
    .followingErrorClass(followingErrorClass),
    .persistentUpdate(persistentUpdate), .persistentAddr(persistentAddr));

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic [31:0] expQ,
                      input logic expE);
    logic [31:0] q;
    logic        e;
    logic        ok;
    bfm.access(w, a, d, q, e, ok);
    if (!ok) begin
      failures++;
      final_report();
    end
    check({31'h0, e}, {31'h0, expE}, "error flag");
    check(q, expQ, "answer data");
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic e);
    xfer(1'b1, a, d, 32'h0, e);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] q,
                    input logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask

  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    check(activeAcceleration, 32'h0000_0258, "reset accel");
    check({30'h0, followingErrorClass}, 32'h3, "reset class");
    for (int i = 0; i < 10; i++) begin
      rd(rstAddr[i], rstVal[i], 1'b0);
    end
    wr(ADDR_PROFILE_ACC, 32'h0000_03E8, 1'b0);
    check({31'h0, persistentUpdate}, 32'h1, "kept mark");
    check({16'h0, persistentAddr}, 32'h0000_0614, "kept addr");
    settle();
    check(activeAcceleration, 32'h0000_03E8, "active accel");
    wr(ADDR_PROFILE_ACC, 32'h0000_0000, 1'b1);
    wr(ADDR_PROFILE_ACC, 32'h002D_C6C1, 1'b1);
    wr(ADDR_PROFILE_DEC, 32'h0000_02ED, 1'b1);
    wr(ADDR_PROFILE_DEC, 32'h002D_C6C1, 1'b1);
    rd(ADDR_PROFILE_ACC, 32'h0000_03E8, 1'b0);
    wr(ADDR_PROFILE_ACC, 32'h002D_C6C0, 1'b0);
    rd(ADDR_PACKED_RAMP, 32'hFFFF_004B, 1'b0);
    rd(ADDR_SYM_RAMP, 32'h0000_FFFF, 1'b0);
    wr(ADDR_PACKED_RAMP, 32'h0064_0050, 1'b0);
    rd(ADDR_PROFILE_ACC, 32'h0000_03E8, 1'b0);
    rd(ADDR_PROFILE_DEC, 32'h0000_0320, 1'b0);
    rd(ADDR_PACKED_RAMP, 32'h0064_0050, 1'b0);
    wr(ADDR_PACKED_RAMP, 32'h00C8_004A, 1'b1);
    rd(ADDR_PROFILE_ACC, 32'h0000_03E8, 1'b0);
    wr(ADDR_SYM_RAMP, 32'h0000_005A, 1'b0);
    check({31'h0, persistentUpdate}, 32'h0, "sym not kept");
    check({16'h0, persistentAddr}, 32'h0000_0602, "last addr");
    rd(ADDR_PROFILE_ACC, 32'h0000_0384, 1'b0);
    rd(ADDR_PROFILE_DEC, 32'h0000_0384, 1'b0);
    wr(ADDR_PROFILE_ACC, 32'h0000_07D0, 1'b0);
    rd(ADDR_SYM_RAMP, 32'h0000_00C8, 1'b0);
    wr(ADDR_SYM_RAMP, 32'h0000_004A, 1'b1);
    rd(ADDR_PROFILE_ACC, 32'h0000_07D0, 1'b0);
    check(activeDeceleration, 32'h0000_0384, "decel");
    softwareStop = 1'b1;
    settle();
    check(activeDeceleration, 32'h0000_1770, "stop ramp");
    softwareStop = 1'b0;
    errorClassOne = 1'b1;
    settle();
    check(activeDeceleration, 32'h0000_1770, "class ramp");
    wr(ADDR_HALT_DECEL, 32'h0000_00C7, 1'b1);
    wr(ADDR_HALT_DECEL, 32'h0000_1F40, 1'b0);
    check({31'h0, persistentUpdate}, 32'h0, "halt not kept");
    settle();
    check(activeDeceleration, 32'h0000_1F40, "new halt ramp");
    errorClassOne = 1'b0;
    wr(ADDR_SPEED_CEIL, 32'h0000_01F4, 1'b0);
    for (int m = 1; m <= 4; m++) begin
      opMode = mrpb_mode_t'(m);
      requestedSpeed = 16'sd800;
      settle();
      check({16'h0, profileSpeed}, 32'h0000_01F4, "clamp up");
      requestedSpeed = -16'sd800;
      settle();
      check({16'h0, profileSpeed}, 32'h0000_FE0C, "clamp down");
    end
    opMode = MRPB_MODE_IDLE;
    requestedSpeed = 16'sd800;
    settle();
    check({16'h0, profileSpeed}, 32'h0000_0320, "pass");
    opMode = MRPB_MODE_SPEED;
    controllerMaxSpeed = 16'd1000;
    analogInputOne = -16'sd300;
    wr(ADDR_SPEED_SETPT, 32'h0000_04B0, 1'b0);
    wr(ADDR_SPEED_SETPT, 32'h0000_7531, 1'b1);
    wr(ADDR_SPEED_SOURCE, 32'h0000_0003, 1'b1);
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_SPEED_SOURCE, s, 1'b0);
      settle();
      check({16'h0, speedCommand}, {16'h0, srcExp[s]}, "source");
    end
    wr(ADDR_FE_LIMIT, 32'h0000_0064, 1'b0);
    wr(ADDR_FE_LIMIT, 32'h001E_8481, 1'b1);
    wr(ADDR_FE_RESPONSE, 32'h0000_0000, 1'b1);
    wr(ADDR_FE_RESPONSE, 32'h0000_0004, 1'b1);
    wr(ADDR_FE_RESPONSE, 32'h0000_0002, 1'b0);
    positionDeviation = 32'sd100;
    seen = 1'b0;
    repeat (4) begin
      @(negedge core_clk);
      seen = seen | followingErrorEvent;
    end
    check({31'h0, seen}, 32'h0, "no event at limit");
    positionDeviation = -32'sd101;
    repeat (4) begin
      @(negedge core_clk);
      seen = seen | followingErrorEvent;
    end
    check({31'h0, seen}, 32'h1, "event");
    check({30'h0, followingErrorClass}, 32'h2, "class");
    rd(16'h0700, 32'h0000_0000, 1'b1);
    final_report();
  end
endmodule // mrpb_ramp_bank_tb_top
